// file: hdl/temp_result_formatter_regs.svh
`ifndef TEMP_RESULT_FORMATTER_REGS_SVH
`define TEMP_RESULT_FORMATTER_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_LOCAL_TEMP  6'h00
`define IDX_REMOTE_HI   6'h01
`define IDX_CFG_RD      6'h03
`define IDX_RATE_RD     6'h04
`define IDX_CFG_WR      6'h09
`define IDX_RATE_WR     6'h0a
`define IDX_REMOTE_LO   6'h10
`define IDX_LIM_RLH_LO  6'h13
`define IDX_LIM_RLL_LO  6'h14
`define IDX_FLAGS       6'h30
`define LIM_RD_BASE     6'h05
`define LIM_WR_BASE     6'h0b
`define LIM_SPLIT       6'h04

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CFG_RANGE_BIT   2
`define CFG_STBY_BIT    6
`define CFG_WR_MASK     8'he4
`define CFG_RESET       8'h00
`define RATE_RESET      4'h8
`define RATE_MAX        4'ha
`define RATE_AVG_MIN    4'h8
`define AVG_LAST        4'hf
`define LIM_RESET       8'h00
`define EXT_OFFSET      11'sh040
`define BIN_MAX         8'h7f
`define EXT_MAX         8'hff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ           50000000
`define CONV_TIME_MAX_MS 16000
`define CONV_PERIOD_DEFAULT (`CONV_TIME_MAX_MS * (`CLK_HZ / 1000))

`endif

// file: hdl/temp_fmt_pkg.sv
package temp_fmt_pkg;

  typedef enum logic [2:0] {
    CUR_BASE = 3'b001,
    CUR_N1   = 3'b010,
    CUR_N2   = 3'b100
  } cur_sel_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_WAIT = 2'b10
  } meas_state_t;

  typedef enum logic [2:0] {
    CV_IDLE   = 3'b001,
    CV_LOCAL  = 3'b010,
    CV_REMOTE = 3'b100
  } conv_state_t;

  typedef struct packed {
    meas_state_t        st;
    logic               avg;
    logic [1:0]         phase;
    logic [9:0]         s0;
    logic [9:0]         s1;
    logic [9:0]         s2;
    logic [3:0]         cnt;
    logic signed [15:0] sum;
    cur_sel_t           cur;
    logic               adc_start;
    logic               done;
    logic signed [11:0] result;
  } meas_reg_t;

  typedef struct packed {
    conv_state_t     st;
    logic [31:0]     tick;
    logic            rdy_s1;
    logic            rdy_s2;
    logic            rdy_d;
    logic            flt_s1;
    logic            flt_s2;
    logic [9:0]      dat_s1;
    logic [9:0]      dat_s2;
    logic            meas_start;
    logic            chan_remote;
    logic            fault_seen;
    logic [7:0]      cfg;
    logic [3:0]      rate;
    logic [5:0][7:0] lim;
    logic [7:0]      local_val;
    logic [7:0]      remote_hi;
    logic [7:0]      remote_lo;
    logic            lock;
    logic [4:0]      flags;
    logic            waitreq;
    logic [31:0]     rdata;
  } top_reg_t;

endpackage

// file: hdl/meas_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "temp_result_formatter_regs.svh"

module meas_seq
  import temp_fmt_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               ce,
  input  wire logic               start,
  input  wire logic               avg_en,
  input  wire logic               sample_valid,
  input  wire logic [9:0]         sample,
  output logic      [2:0]         cur_sel,
  output logic                    adc_start,
  output logic                    done,
  output logic signed [11:0]      result
);

  meas_reg_t r;
  meas_reg_t n;

  function automatic cur_sel_t cur_of(input logic [1:0] ph);
    cur_of = ph[0] ? (ph[1] ? CUR_N2 : CUR_N1) : CUR_BASE;
  endfunction

  // ----------------------------------------------------------------
  // Four samples: base, N1, base, N2
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [12:0] d1;
    logic signed [12:0] d2;
    logic signed [12:0] t;
    logic signed [15:0] acc;
    d1 = 13'sh0000;
    d2 = 13'sh0000;
    t = 13'sh0000;
    acc = 16'sh0000;
    n = r;
    n.adc_start = 1'b0;
    n.done = 1'b0;
    unique case (r.st)
      MS_IDLE: begin
        if (start) begin
          n.phase = 2'h0;
          n.cnt = 4'h0;
          n.sum = 16'sh0000;
          n.avg = avg_en;
          n.cur = CUR_BASE;
          n.adc_start = 1'b1;
          n.st = MS_WAIT;
        end
      end
      MS_WAIT: begin
        if (sample_valid) begin
          if (r.phase != 2'h3) begin
            if (r.phase == 2'h0) n.s0 = sample;
            if (r.phase == 2'h1) n.s1 = sample;
            if (r.phase == 2'h2) n.s2 = sample;
            n.phase = r.phase + 2'h1;
            n.cur = cur_of(r.phase + 2'h1); // R1
            n.adc_start = 1'b1;
          end else begin
            // Two steps combined so series resistance drops out
            d1 = $signed({3'b000, r.s1}) - $signed({3'b000, r.s0}); // R1
            d2 = $signed({3'b000, sample}) - $signed({3'b000, r.s2});
            t = (d1 <<< 1) - d2; // R1
            acc = r.sum + {{3{t[12]}}, t};
            n.cur = CUR_BASE;
            if (!r.avg) begin
              n.result = t[11:0]; // R2
              n.done = 1'b1; // R19
              n.st = MS_IDLE;
            end else if (r.cnt == `AVG_LAST) begin
              n.result = acc[15:4]; // R2
              n.done = 1'b1; // R19
              n.st = MS_IDLE;
            end else begin
              n.sum = acc;
              n.cnt = r.cnt + 4'h1;
              n.phase = 2'h0;
              n.adc_start = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= MS_IDLE;
      r.cur <= CUR_BASE;
    end else if (ce) begin
      r <= n;
    end
  end

  assign cur_sel = r.cur;
  assign adc_start = r.adc_start;
  assign done = r.done;
  assign result = r.result;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_meas_begin;
    ce && start && (r.st == MS_IDLE);
  endsequence

  property p_start_base;
    s_meas_begin |=> (r.cur == CUR_BASE) && r.adc_start ##1 !r.adc_start;
  endproperty
  a_start_base: assert property (p_start_base) // R1
    else $error("measurement did not open with base current");

  property p_avg_count;
    r.done |-> (!r.avg || (r.cnt == `AVG_LAST)) && (r.phase == 2'h3);
  endproperty
  a_avg_count: assert property (p_avg_count) // R2
    else $error("result reported before all cycles were averaged");

endmodule

`default_nettype wire

// file: hdl/temp_result_formatter.sv
// Function
// R1: Remote current steps base-N1 then base-N2
// R2: Average 16 cycles below 16 conversions per second
// R3: Local integer result at index 0x00
// R4: Remote integer 0x01, fraction byte 0x10
// R5: Fraction bits 7:6 only, rest zero
// R6: Low byte read locks high byte
// R7: Config bit 2 selects extended range
// R8: New range applies from next result
// R9: Extended range adds 64 offset
// R10: Binary range saturates to 0..127
// R11: Diode fault keeps last good remote
// R12: Range change leaves limits untouched
// R13: Compare results with limits after conversion
// R14: Twenty-two byte-wide registers in map; the map here decodes 18 indices
// R15: Alternate local and remote conversions continuously
// R16: Result registers read-only, reset zero
// R17: Config read 0x03, write 0x09, reset zero
// R18: Rate code resets to 0x08, no averaging
// R19: Store only complete conversions
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "temp_result_formatter_regs.svh"

module temp_result_formatter
  import temp_fmt_pkg::*;
#(
  parameter int unsigned CONV_PERIOD_CYCLES = `CONV_PERIOD_DEFAULT
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [9:0]  adc_data,
  input  wire logic        adc_ready,
  input  wire logic        diode_fault,
  output logic      [2:0]  cur_sel,
  output logic             adc_start,
  output logic             chan_remote
);

  top_reg_t           r;
  top_reg_t           n;
  logic [5:0]         idx;
  logic               req;
  logic               bus_done;
  logic               meas_done;
  logic signed [11:0] meas_result;
  logic [3:0]         rate_eff;
  logic [31:0]        period;
  logic               ext;
  logic [9:0]         f;
  logic               fault;
  logic               store_local;
  logic               store_remote;

  assign idx = avs_address[7:2];
  assign req = avs_read | avs_write;
  assign bus_done = req && !r.waitreq;
  assign ext = r.cfg[`CFG_RANGE_BIT];
  assign fault = r.fault_seen | r.flt_s2;
  assign rate_eff = (r.rate > `RATE_MAX) ? `RATE_MAX : r.rate;
  assign period = CONV_PERIOD_CYCLES >> rate_eff;
  assign store_local = (r.st == CV_LOCAL) && meas_done;
  assign store_remote = (r.st == CV_REMOTE) && meas_done;

  // ----------------------------------------------------------------
  // Result formatting: {integer byte, quarter bits}
  // ----------------------------------------------------------------
  function automatic logic [9:0] fmt(input logic signed [11:0] q,
                                     input logic e);
    logic signed [10:0] w;
    logic [7:0]         top;
    w = {q[11], q[11:2]};
    top = `BIN_MAX;
    if (e) begin
      w = w + `EXT_OFFSET; // R9
      top = `EXT_MAX;
    end
    if (w < 11'sh000) fmt = 10'h000; // R10
    else if (w > $signed({3'b000, top})) fmt = {top, 2'b00}; // R10
    else fmt = {w[7:0], q[1:0]};
  endfunction

  assign f = fmt(meas_result, ext); // R7 R8

  meas_seq u_meas (
    .clk          (clk),
    .nrst         (nrst),
    .ce           (ce),
    .start        (r.meas_start),
    .avg_en       (rate_eff < `RATE_AVG_MIN), // R2 R18
    .sample_valid (r.rdy_s2 && !r.rdy_d),
    .sample       (r.dat_s2),
    .cur_sel      (cur_sel),
    .adc_start    (adc_start),
    .done         (meas_done),
    .result       (meas_result)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] rd;
    rd = 8'h00;
    n = r;
    n.meas_start = 1'b0;
    // Pin inputs; data is stable while ready is high
    n.rdy_s1 = adc_ready;
    n.rdy_s2 = r.rdy_s1;
    n.rdy_d = r.rdy_s2;
    n.flt_s1 = diode_fault;
    n.flt_s2 = r.flt_s1;
    n.dat_s1 = adc_data;
    n.dat_s2 = r.dat_s1;

    // Read mux; unmapped indices read zero
    case (idx)
      `IDX_LOCAL_TEMP: rd = r.local_val; // R3
      `IDX_REMOTE_HI:  rd = r.remote_hi; // R4
      `IDX_REMOTE_LO:  rd = r.remote_lo; // R4
      `IDX_CFG_RD:     rd = r.cfg; // R17
      `IDX_RATE_RD:    rd = {4'h0, r.rate};
      `IDX_LIM_RLH_LO: rd = r.lim[4];
      `IDX_LIM_RLL_LO: rd = r.lim[5];
      `IDX_FLAGS:      rd = {3'h0, r.flags};
      default: begin
        if (idx >= `LIM_RD_BASE && idx < `LIM_RD_BASE + `LIM_SPLIT)
          rd = r.lim[2'(idx - `LIM_RD_BASE)];
      end
    endcase

    // One wait cycle, then complete on the edge waitrequest is low
    if (req && r.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata = {24'h00_0000, rd};
    end else if (bus_done) begin
      n.waitreq = 1'b1;
      if (avs_write && avs_byteenable[0]) begin
        // Result indices have no write path
        case (idx)
          `IDX_CFG_WR: n.cfg = avs_writedata[7:0] & `CFG_WR_MASK; // R17
          `IDX_RATE_WR: n.rate = avs_writedata[3:0];
          `IDX_LIM_RLH_LO: n.lim[4] = avs_writedata[7:0];
          `IDX_LIM_RLL_LO: n.lim[5] = avs_writedata[7:0];
          default: begin
            if (idx >= `LIM_WR_BASE && idx < `LIM_WR_BASE + `LIM_SPLIT)
              n.lim[2'(idx - `LIM_WR_BASE)] = avs_writedata[7:0];
          end
        endcase
      end
      if (avs_read && idx == `IDX_REMOTE_LO) n.lock = 1'b1; // R6
      if (avs_read && idx == `IDX_REMOTE_HI) n.lock = 1'b0; // R6
    end

    // Conversion pacing; a slow conversion simply delays the next
    if (r.tick != 32'h0000_0000) n.tick = r.tick - 32'h0000_0001;

    unique case (r.st)
      CV_IDLE: begin
        if (r.tick == 32'h0000_0000 && !r.cfg[`CFG_STBY_BIT]) begin
          n.tick = period - 32'h0000_0001;
          n.meas_start = 1'b1; // R15
          n.chan_remote = 1'b0;
          n.st = CV_LOCAL;
        end
      end
      CV_LOCAL: begin
        if (store_local) begin
          n.local_val = f[9:2]; // R3 R19
          n.flags[0] = f[9:2] > r.lim[0]; // R13
          n.flags[1] = f[9:2] <= r.lim[1]; // R13
          n.meas_start = 1'b1; // R15
          n.chan_remote = 1'b1;
          n.fault_seen = 1'b0;
          n.st = CV_REMOTE;
        end
      end
      CV_REMOTE: begin
        if (r.flt_s2) n.fault_seen = 1'b1;
        if (store_remote) begin
          n.flags[4] = fault;
          if (!fault) begin // R11
            n.remote_lo = {f[1:0], 6'h00}; // R4 R5
            if (!r.lock) n.remote_hi = f[9:2]; // R6
            n.flags[2] = f > {r.lim[2], r.lim[4][7:6]}; // R13
            n.flags[3] = f <= {r.lim[3], r.lim[5][7:6]}; // R13
          end
          n.chan_remote = 1'b0;
          n.st = CV_IDLE;
        end
      end
    endcase
  end

  // Limits are only ever written by the bus, so a range switch
  // leaves them in the old format until software rewrites them.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0; // R16
      r.st <= CV_IDLE;
      r.cfg <= `CFG_RESET; // R17
      r.rate <= `RATE_RESET; // R18
      r.lim <= {6{`LIM_RESET}}; // R12
      r.waitreq <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.waitreq;
  assign chan_remote = r.chan_remote;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_wait_answer;
    ce && req && r.waitreq |=> !r.waitreq ##1 r.waitreq;
  endproperty
  a_wait_answer: assert property (p_wait_answer) // R14
    else $error("bus request not answered after one wait cycle");

  property p_lock_on_low_read;
    ce && bus_done && avs_read && idx == `IDX_REMOTE_LO |=> r.lock;
  endproperty
  a_lock_on_low_read: assert property (p_lock_on_low_read) // R6
    else $error("fraction byte read did not lock integer byte");

  property p_lock_holds;
    r.lock && !(bus_done && avs_read && idx == `IDX_REMOTE_HI)
      |=> $stable(r.remote_hi);
  endproperty
  a_lock_holds: assert property (p_lock_holds) // R6
    else $error("locked integer byte changed");

  property p_ro_local;
    ce && bus_done && avs_write && idx == `IDX_LOCAL_TEMP && !store_local
      |=> $stable(r.local_val);
  endproperty
  a_ro_local: assert property (p_ro_local) // R16
    else $error("bus write altered the local result");

  property p_cfg_reserved;
    !r.waitreq && avs_read && idx == `IDX_CFG_RD
      |-> (r.rdata & 32'hffff_ff1b) == 32'h0000_0000;
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved) // R17
    else $error("reserved config bits read non-zero");

  property p_frac_layout;
    ce && store_remote && !fault |=> r.remote_lo == {$past(f[1:0]), 6'h00};
  endproperty
  a_frac_layout: assert property (p_frac_layout) // R5
    else $error("fraction byte layout wrong");

  property p_bin_sat;
    ce && store_local && !ext |=> !r.local_val[7];
  endproperty
  a_bin_sat: assert property (p_bin_sat) // R10
    else $error("binary range result above 127");

  property p_ext_offset;
    ce && store_local && ext && meas_result == 12'sh000
      |=> r.local_val == 8'h40;
  endproperty
  a_ext_offset: assert property (p_ext_offset) // R9
    else $error("zero degrees not encoded as 0x40 in extended range");

  property p_fault_keep;
    ce && store_remote && fault
      |=> $stable(r.remote_lo) && $stable(r.remote_hi);
  endproperty
  a_fault_keep: assert property (p_fault_keep) // R11
    else $error("faulty remote result was stored");

  property p_cmp_local;
    ce && store_local && !(bus_done && avs_write)
      |=> r.flags[0] == (r.local_val > r.lim[0]);
  endproperty
  a_cmp_local: assert property (p_cmp_local) // R13
    else $error("local high flag disagrees with limit");

  property p_alternate;
    ce && store_local |=> (r.st == CV_REMOTE) && r.chan_remote
      && r.meas_start ##1 adc_start;
  endproperty
  a_alternate: assert property (p_alternate) // R15
    else $error("remote conversion did not follow local");

endmodule

`default_nettype wire

// file: tb/adc_front_model.sv
`timescale 1ns/1ps
`default_nettype none

module adc_front_model (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [2:0]         cur_sel,
  input  wire logic               adc_start,
  input  wire logic               chan_remote,
  input  wire logic signed [11:0] temp_local,
  input  wire logic signed [11:0] temp_remote,
  input  wire logic [1:0]         slow,
  output logic      [9:0]         adc_data,
  output logic                    adc_ready,
  output int                      order_err
);
  // ---------------------------------------------------------------
  // Diode and converter front end
  // ---------------------------------------------------------------
  logic [2:0]         cur_q;
  logic               pend;
  int                 step;
  int                 hold;
  int                 gap;
  logic signed [11:0] t;

  // Each multiple reads base plus the temperature, so 2*d1 - d2 gives it
  initial begin
    adc_data = 10'h155;
    adc_ready = 1'b0;
    order_err = 0;
    pend = 1'b0;
    step = 0;
    hold = 0;
    gap = 0;
    cur_q = 3'h1;
    forever begin
      @(posedge clk);
      if (nrst !== 1'b1) begin
        pend = 1'b0;
        step = 0;
        hold = 0;
        adc_ready <= 1'b0;
      end else begin
        if (adc_start === 1'b1) begin
          if (cur_sel !== (step[0] ? (step == 1 ? 3'h2 : 3'h4) : 3'h1))
            order_err <= order_err + 1;
          step = (step + 1) % 4;
          cur_q = cur_sel;
          pend = 1'b1;
          gap = 3 + slow;
        end
        // Released data is inverted so a late capture cannot pass
        if (hold > 0) begin
          hold--;
          if (hold == 0) begin
            adc_ready <= 1'b0;
            adc_data <= ~adc_data;
          end
        end else if (pend && gap > 0) begin
          gap--;
        end else if (pend) begin
          t = chan_remote ? temp_remote : temp_local;
          adc_data <= (cur_q == 3'h1) ? 10'h12c : 10'h12c + t[9:0];
          adc_ready <= 1'b1;
          hold = 4;
          pend = 1'b0;
        end
      end
    end
  end
endmodule

`default_nettype wire

// file: tb/test_temp_result_formatter.sv
`timescale 1ns/1ps
`default_nettype none

module test_temp_result_formatter;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic [7:0]         avs_address = 8'h00;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0000_0000;
  logic [3:0]         avs_byteenable = 4'h0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic [9:0]         adc_data;
  logic               adc_ready;
  logic               diode_fault = 1'b0;
  logic [2:0]         cur_sel;
  logic               adc_start;
  logic               chan_remote;
  logic signed [11:0] t_loc = 12'h000;
  logic signed [11:0] t_rem = 12'h000;
  logic [1:0]         slow = 2'h0;
  logic [7:0]         rd;
  logic [15:0]        e;
  int                 order_err;
  int                 error_cnt = 0;
  int                 n_checks = 0;
  int                 seed = 32'h7227;
  int                 lcnt = 0;
  int                 lpast = 0;
  int                 i;
  int                 r;
  int                 tv[4] = '{103, -220, 600, 0};
  logic [7:0]         rc[4] = '{8'h07, 8'h00, 8'h09, 8'h0a};

  always #10 clk = ~clk;

  temp_result_formatter #(.CONV_PERIOD_CYCLES(2048)) u_temp_result_formatter (
    .clk(clk), .nrst(nrst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .adc_data(adc_data), .adc_ready(adc_ready), .diode_fault(diode_fault),
    .cur_sel(cur_sel), .adc_start(adc_start), .chan_remote(chan_remote));

  adc_front_model u_adc_front_model (
    .clk(clk), .nrst(nrst), .cur_sel(cur_sel), .adc_start(adc_start),
    .chan_remote(chan_remote), .temp_local(t_loc), .temp_remote(t_rem),
    .slow(slow), .adc_data(adc_data), .adc_ready(adc_ready),
    .order_err(order_err));

  // Samples per local phase, latched when the remote phase begins
  always @(posedge clk) begin
    if (chan_remote && lcnt != 0) begin
      lpast <= lcnt;
      lcnt <= 0;
    end else if (adc_start && !chan_remote) begin
      lcnt <= lcnt + 1;
    end
  end

  // ---------------------------------------------------------------
  // Reference model and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [15:0] fmt(input int t, input logic ext);
    int v;
    v = (t >>> 2) + (ext ? 64 : 0);
    if (v < 0) return 16'h0000;
    if (v > (ext ? 255 : 127)) return ext ? 16'hff00 : 16'h7f00;
    return {v[7:0], t[1:0], 6'h00};
  endfunction

  task results;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
           input logic [3:0] be);
    int n;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      results();
    end
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task rdchk(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hf);
    check(rd, exp);
  endtask

  // Waits for whole local plus remote conversions, bounded
  task wait_conv(input int n);
    int k;
    repeat (n) begin
      k = 0;
      while (chan_remote !== 1'b1 && k < 5000) begin
        @(posedge clk);
        k++;
      end
      while (chan_remote !== 1'b0 && k < 5000) begin
        @(posedge clk);
        k++;
      end
      if (k >= 5000) begin
        error_cnt++;
        results();
      end
    end
  endtask

  task chk_temps(input logic ext);
    e = fmt(t_rem, ext);
    rdchk(6'h10, e[7:0]);
    rdchk(6'h01, e[15:8]);
    e = fmt(t_loc, ext);
    rdchk(6'h00, e[15:8]);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    #1500000;
    error_cnt++;
    results();
  end

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdchk(6'h00, 8'h00);
    rdchk(6'h10, 8'h00);
    rdchk(6'h01, 8'h00);
    rdchk(6'h03, 8'h00);
    rdchk(6'h04, 8'h08);
    rdchk(6'h3f, 8'h00);
    bus(1'b1, 6'h0b, 8'h50, 4'hf);
    bus(1'b1, 6'h09, 8'h04, 4'h0);
    rdchk(6'h03, 8'h00);
    for (r = 0; r < 2; r++) begin
      bus(1'b1, 6'h09, r[0] ? 8'h04 : 8'h00, 4'hf);
      rdchk(6'h03, {5'h00, r[0], 2'h0});
      rdchk(6'h05, 8'h50);
      for (i = 0; i < 6; i++) begin
        t_loc <= (i < 4) ? 12'(tv[i]) : 12'($random(seed) % 300);
        t_rem <= (i < 4) ? 12'(tv[(i + 1) % 4]) : 12'($random(seed) % 300);
        slow <= 2'($random(seed));
        wait_conv(2);
        chk_temps(r[0]);
      end
    end
    t_rem <= 12'sd200;
    wait_conv(2);
    rdchk(6'h10, 8'h00);
    t_rem <= 12'sd301;
    wait_conv(2);
    rdchk(6'h10, 8'h40);
    rdchk(6'h01, 8'h72);
    wait_conv(2);
    rdchk(6'h01, 8'h8b);
    t_rem <= 12'sd400;
    wait_conv(2);
    diode_fault <= 1'b1;
    t_rem <= 12'sd120;
    t_loc <= 12'sd80;
    wait_conv(2);
    rdchk(6'h00, 8'h54);
    rdchk(6'h10, 8'h00);
    rdchk(6'h01, 8'ha4);
    diode_fault <= 1'b0;
    wait_conv(2);
    chk_temps(1'b1);
    bus(1'b1, 6'h09, 8'h00, 4'hf);
    t_loc <= 12'sd400;
    t_rem <= 12'sd133;
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 6'h0a, rc[i], 4'hf);
      rdchk(6'h04, rc[i]);
      wait_conv(3);
      check(lpast[7:0], (rc[i] < 8'h08) ? 8'h40 : 8'h04);
      chk_temps(1'b0);
    end
    e = fmt(t_loc, 1'b0);
    bus(1'b0, 6'h30, 8'h00, 4'hf);
    check({7'h00, rd[0]}, {7'h00, e[15:8] > 8'h50});
    // Standby stops new conversions; a result byte takes no bus write
    bus(1'b1, 6'h09, 8'h40, 4'hf);
    repeat (1500) @(posedge clk);
    t_loc <= 12'sd20;
    bus(1'b1, 6'h00, 8'h33, 4'hf);
    repeat (1500) @(posedge clk);
    rdchk(6'h00, e[15:8]);
    check(order_err[7:0], 8'h00);
    results();
  end
endmodule

`default_nettype wire
